// ==== srlc_pkg.sv ====
// constants shared by the relay latch chain and its driver stages
// assumes a 200 MHz core clock
package srlc_pkg;

  // chain shape: bytes per card, bits per driver stage
  localparam int unsigned STAGES          = 16;
  localparam int unsigned STAGE_W         = 8;
  localparam int unsigned RELAYS          = STAGES * STAGE_W;

  // core clock and power-on hold-off
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned HOLDOFF_MS      = 470;
  localparam int unsigned HOLDOFF_CYC     = HOLDOFF_MS * (CLK_HZ / 1000);

  // isolator relay numbers (relay n sits on drive bit n-1)
  localparam int unsigned ROW_ISO_FIRST   = 121;
  localparam int unsigned ROW_ISO_LAST    = 128;
  localparam int unsigned COL_ISO_A_FIRST = 25;
  localparam int unsigned COL_ISO_A_LAST  = 36;
  localparam int unsigned COL_ISO_B_FIRST = 85;
  localparam int unsigned COL_ISO_B_LAST  = 96;

  // reset values
  localparam logic        OE_N_RST        = 1'b1;

endpackage

// ==== srlc_stage.sv ====
// one serial-in latching driver stage: shift register, output latch, driver
// assumes shift and load pulses come from logic on the same clock
module srlc_stage
  import srlc_pkg::*;
#(
  parameter int unsigned W = STAGE_W
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // chain side
  input  wire logic         i_shift,
  input  wire logic         i_ser_in,
  output logic              o_ser_out,
  // latch and drive
  input  wire logic         i_load,
  input  wire logic         i_oe_n,
  output logic [W-1:0]      o_shift,
  output logic [W-1:0]      o_latch,
  output logic [W-1:0]      o_drive_n
);

  logic [W-1:0] shift_r;
  logic [W-1:0] latch_r;
  logic [W-1:0] drive_n_r;

  // shift one bit per link clock rise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_r <= '0;
    end else if (i_shift) begin
      shift_r <= {shift_r[W-2:0], i_ser_in};
    end
  end

  // latch copies the shift register only on a strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      latch_r <= '0;
    end else if (i_load) begin
      latch_r <= shift_r;
    end
  end

  // active-low drivers, all off while disabled
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_n_r <= '1;
    end else if (i_oe_n) begin
      drive_n_r <= '1;
    end else begin
      drive_n_r <= ~latch_r;
    end
  end

  assign o_ser_out = shift_r[W-1];
  assign o_shift   = shift_r;
  assign o_latch   = latch_r;
  assign o_drive_n = drive_n_r;

endmodule

// ==== srlc_top.sv ====
// relay control path of a switching matrix card: serial chain, strobe, safeguard
// assumes link clock, serial data and strobe come from another clock domain
module srlc_top
  import srlc_pkg::*;
#(
  parameter int unsigned N_STAGES = STAGES,
  parameter int unsigned HOLD_CYC = HOLDOFF_CYC
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  // link from controller
  input  wire logic                      i_link_clk,
  input  wire logic                      i_relay_serial_in,
  input  wire logic                      i_strobe,
  // chain output to the next card
  output logic                           o_chain_serial_out,
  // relay drivers
  output logic [N_STAGES*STAGE_W-1:0]    o_relay_drive_n,
  output logic                           o_driver_output_enable_n,
  output logic                           o_isolator_energized
);

  localparam int unsigned NB    = N_STAGES * STAGE_W;
  localparam int unsigned CNT_W = $clog2(HOLD_CYC + 1);

  // isolator relay positions on the drive vector
  function automatic logic [NB-1:0] iso_mask();
    logic [NB-1:0] m;
    m = '0;
    for (int unsigned n = 1; n <= NB; n++) begin
      if ((n >= ROW_ISO_FIRST && n <= ROW_ISO_LAST) ||
          (n >= COL_ISO_A_FIRST && n <= COL_ISO_A_LAST) ||
          (n >= COL_ISO_B_FIRST && n <= COL_ISO_B_LAST)) begin
        m[n-1] = 1'b1;
      end
    end
    return m;
  endfunction

  localparam logic [NB-1:0] ISO_MASK = iso_mask();

  logic [2:0]        lclk_sync_r;
  logic [1:0]        data_sync_r;
  logic [2:0]        strb_sync_r;
  logic              link_rise;
  logic              strobe_rise;
  logic [CNT_W-1:0]  hold_cnt_r;
  logic              holdoff_done_r;
  logic              oe_n_r;
  logic              iso_r;
  logic [N_STAGES:0] chain;
  logic [NB-1:0]     shift_w;
  logic [NB-1:0]     latch_w;
  logic [NB-1:0]     drive_w;
  logic [NB-1:0]     shift_expect;

  // two-flop synchronisers, third flop only for edge finding
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lclk_sync_r <= '0;
      data_sync_r <= '0;
      strb_sync_r <= '0;
    end else begin
      lclk_sync_r <= {lclk_sync_r[1:0], i_link_clk};
      data_sync_r <= {data_sync_r[0], i_relay_serial_in};
      strb_sync_r <= {strb_sync_r[1:0], i_strobe};
    end
  end

  assign link_rise   = lclk_sync_r[1] & ~lclk_sync_r[2];
  assign strobe_rise = strb_sync_r[1] & ~strb_sync_r[2];

  // power-on hold-off timer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_cnt_r     <= '0;
      holdoff_done_r <= 1'b0;
    end else if (!holdoff_done_r) begin
      hold_cnt_r <= hold_cnt_r + CNT_W'(1);
      if (hold_cnt_r == CNT_W'(HOLD_CYC - 1)) begin
        holdoff_done_r <= 1'b1;
      end
    end
  end

  // safeguard flip-flop: set at power-up, cleared by first armed strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      oe_n_r <= OE_N_RST;
    end else if (strobe_rise && holdoff_done_r) begin
      oe_n_r <= 1'b0;
    end
  end

  // chain of driver stages, stage 0 takes the serial input
  assign chain[0] = data_sync_r[1];

  genvar g;
  generate
    for (g = 0; g < N_STAGES; g++) begin : g_stage
      srlc_stage #(
        .W          (STAGE_W)
      ) u_stage (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_shift    (link_rise),
        .i_ser_in   (chain[g]),
        .o_ser_out  (chain[g+1]),
        .i_load     (strobe_rise),
        .i_oe_n     (oe_n_r),
        .o_shift    (shift_w[g*STAGE_W +: STAGE_W]),
        .o_latch    (latch_w[g*STAGE_W +: STAGE_W]),
        .o_drive_n  (drive_w[g*STAGE_W +: STAGE_W])
      );
    end
  endgenerate

  // any isolator relay currently energized
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iso_r <= 1'b0;
    end else begin
      iso_r <= |(~drive_w & ISO_MASK);
    end
  end

  assign o_chain_serial_out       = chain[N_STAGES];
  assign o_relay_drive_n          = drive_w;
  assign o_driver_output_enable_n = oe_n_r;
  assign o_isolator_energized     = iso_r;

  assign shift_expect = {shift_w[NB-2:0], data_sync_r[1]};

  // assertions
  sequence s_armed_strobe;
    strobe_rise && holdoff_done_r;
  endsequence

  sequence s_enabled;
    !oe_n_r ##1 !oe_n_r;
  endsequence

  a_holdoff_keeps_off: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !holdoff_done_r |-> oe_n_r)
    else $error("outputs enabled during hold-off");

  a_first_strobe_clr: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    s_armed_strobe |=> s_enabled)
    else $error("armed strobe did not enable drivers");

  a_oe_needs_strobe: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    oe_n_r && !(strobe_rise && holdoff_done_r) |=> oe_n_r)
    else $error("safeguard cleared without strobe");

  a_off_while_safe: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    oe_n_r |=> (o_relay_drive_n == '1))
    else $error("relay energized while safeguard set");

  a_drive_active_lo: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !oe_n_r |=> (o_relay_drive_n == ~$past(latch_w)))
    else $error("drive output not inverse of latch");

  a_strobe_copies: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    strobe_rise |=> (latch_w == $past(shift_w)))
    else $error("strobe did not copy shift register");

  a_latch_holds: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !strobe_rise |=> $stable(latch_w))
    else $error("latch changed without strobe");

  a_chain_shift: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    link_rise |=> (shift_w == $past(shift_expect)))
    else $error("chain did not shift one position");

  a_shift_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !link_rise |=> $stable(shift_w))
    else $error("chain shifted without link clock rise");

  a_iso_flag: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    |(~o_relay_drive_n & ISO_MASK) |=> o_isolator_energized)
    else $error("isolator flag missed energized isolator");

  a_enable_sticky: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !oe_n_r |=> !oe_n_r)
    else $error("safeguard set again after enable");

  a_iso_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !(|(~o_relay_drive_n & ISO_MASK)) |=> !o_isolator_energized)
    else $error("isolator flag set with no isolator energized");

endmodule

// ==== srlc_ctrl_model.sv ====
// controller model: shifts relay frames through the link and pulses the strobe
// assumes the card samples link clock, data and strobe with its own clock
module srlc_ctrl_model
  import srlc_pkg::*;
(
  // link to the card
  output logic o_link_clk,
  output logic o_ser_data,
  output logic o_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_link_clk = 1'b0;
    o_ser_data = 1'b0;
    o_strobe   = 1'b0;
  end
  // one whole frame, relay 128 first; link clock idles low between frames
  // called on a core clock edge; non-blocking updates land after that edge samples
  task automatic send_frame(input logic [RELAYS-1:0] d);
    for (int i = RELAYS - 1; i >= 0; i--) begin
      o_ser_data <= d[i];
      #40 o_link_clk <= 1'b1;
      #40 o_link_clk <= 1'b0;
    end
    o_ser_data <= ~d[0];
  endtask
  // strobe only once every card holds its full frame
  task automatic pulse_strobe();
    #40 o_strobe <= 1'b1;
    #40 o_strobe <= 1'b0;
  endtask
endmodule

// ==== srlc_top_test.sv ====
// self-checking bench for the relay latch chain with a controller model
// assumes a shortened hold-off parameter and a 200 MHz core clock
module srlc_top_test;
  import srlc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HOLD  = 50;
  localparam int unsigned LIMIT = 20000;
  localparam logic [RELAYS-1:0] ONES  = '1;
  localparam logic [RELAYS-1:0] PAT_A = 128'h00A55A00_00000000_00000F00_00C30081;
  // crosspoint C10 with its isolators: relays 34, 46, 123, plus row isolator 128
  localparam logic [RELAYS-1:0] PAT_B = 128'h84000000_00000000_00002002_00000000;
  logic              clk;
  logic              rst_b;
  logic              link_clk;
  logic              ser_data;
  logic              strobe;
  logic              ser_out;
  logic [RELAYS-1:0] drive_n;
  logic              oe_n;
  logic              iso;
  int                fail_count = 0;
  int                n_compared = 0;
  int                cycles     = 0;
  srlc_ctrl_model ctrl (.o_link_clk(link_clk), .o_ser_data(ser_data), .o_strobe(strobe));
  srlc_top #(.N_STAGES(STAGES), .HOLD_CYC(HOLD)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_link_clk(link_clk), .i_relay_serial_in(ser_data),
    .i_strobe(strobe), .o_chain_serial_out(ser_out), .o_relay_drive_n(drive_n),
    .o_driver_output_enable_n(oe_n), .o_isolator_energized(iso));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [RELAYS-1:0] got, input logic [RELAYS-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t drives got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask
  task automatic t_reset();
    chk_bit(oe_n, 1'b1, "enable");
    chk_vec(drive_n, ONES);
    chk_bit(ser_out, 1'b0, "chain");
    chk_bit(iso, 1'b0, "isolator");
    $display("test reset done");
  endtask
  task automatic t_early();
    ctrl.pulse_strobe();
    settle();
    chk_bit(oe_n, 1'b1, "enable");
    chk_vec(drive_n, ONES);
    $display("test early strobe done");
  endtask
  task automatic t_enable();
    repeat (HOLD) @(posedge clk);
    ctrl.send_frame(PAT_A);
    settle();
    chk_bit(ser_out, PAT_A[RELAYS-1], "chain");
    chk_vec(drive_n, ONES);
    ctrl.pulse_strobe();
    settle();
    chk_bit(oe_n, 1'b0, "enable");
    chk_vec(drive_n, ~PAT_A);
    chk_bit(iso, 1'b0, "isolator");
    $display("test enable done");
  endtask
  task automatic t_hold();
    ctrl.send_frame(PAT_B);
    settle();
    chk_vec(drive_n, ~PAT_A);
    chk_bit(ser_out, PAT_B[RELAYS-1], "chain");
    ctrl.pulse_strobe();
    settle();
    chk_vec(drive_n, ~PAT_B);
    chk_bit(iso, 1'b1, "isolator");
    $display("test hold and crosspoint done");
  endtask
  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_early();
    t_enable();
    t_hold();
    conclude();
  end
endmodule
